// file: common/fps_pkg.sv
// Purpose: shared constants for the fiber partner status register bank
// Assumes: APB with 32-bit data, one register per aligned word
// Notes: printed offsets are register indices; byte address is four times the index
package fps_pkg;
  // register indices and byte addresses
  localparam logic [7:0] IDX_PARTNER = 8'h05;
  localparam logic [7:0] IDX_EXPANSION = 8'h06;
  localparam logic [7:0] IDX_IRQ_STATUS = 8'h10;
  localparam logic [7:0] IDX_IRQ_MASK = 8'h11;
  localparam logic [7:0] IDX_CONTROL = 8'h12;
  localparam logic [9:0] ADDR_PARTNER = {IDX_PARTNER, 2'b00};
  localparam logic [9:0] ADDR_EXPANSION = {IDX_EXPANSION, 2'b00};
  localparam logic [9:0] ADDR_IRQ_STATUS = {IDX_IRQ_STATUS, 2'b00};
  localparam logic [9:0] ADDR_IRQ_MASK = {IDX_IRQ_MASK, 2'b00};
  localparam logic [9:0] ADDR_CONTROL = {IDX_CONTROL, 2'b00};
  // reset values
  localparam logic [15:0] PARTNER_RST = 16'h0000;
  localparam logic [1:0] MODE_RST = 2'b11;
  // fiber mode select encodings
  localparam logic [1:0] MODE_1000BX = 2'b01;
  localparam logic [1:0] MODE_SGMII_SYS = 2'b10;
  localparam logic [1:0] MODE_SGMII_MEDIA = 2'b11;
  // expansion field positions and the code word next-page bit
  localparam int EXP_PEER_NP = 3;
  localparam int EXP_LOCAL_NP = 2;
  localparam int EXP_PAGE_RX = 1;
  localparam int EXP_PEER_AN = 0;
  localparam int CW_NEXT_PAGE = 15;
  // control field positions
  localparam int CTL_AN_ENABLE = 2;
  // irq status bit positions
  localparam int IRQ_PAGE = 0;
  localparam int IRQ_LINK_DOWN = 1;
  localparam int IRQ_PEER_AN = 2;
  // matching config code groups needed before the partner counts as able
  localparam logic [1:0] MATCH_NEED = 2'd3;
  typedef enum logic [1:0] {FPS_HUNT = 2'b00, FPS_ONE = 2'b01, FPS_TWO = 2'b11, FPS_ABLE = 2'b10} fps_match_t;
endpackage

// file: core/fps_match.sv
// Purpose: detects three matching non-zero configuration code groups
// Assumes: code groups arrive as single-cycle strobes with their word
// Notes: any loss of sync or mismatch restarts the count
module fps_match (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic sync_ok,
  input wire logic cfg_valid,
  input wire logic [15:0] cfg_word,
  output logic matched
);
  fps_pkg::fps_match_t state_q;
  fps_pkg::fps_match_t state_d;
  logic [15:0] last_q;
  wire logic nonzero = |cfg_word;
  wire logic same = cfg_word == last_q;

  // count consecutive identical non-zero groups while in sync
  always_comb
  begin
    state_d = state_q;
    if (!sync_ok)
      state_d = fps_pkg::FPS_HUNT;
    else if (cfg_valid)
    begin
      if (!nonzero)
        state_d = fps_pkg::FPS_HUNT;
      else
        case (state_q)
          fps_pkg::FPS_HUNT: state_d = fps_pkg::FPS_ONE;
          fps_pkg::FPS_ONE: state_d = same ? fps_pkg::FPS_TWO : fps_pkg::FPS_ONE;
          fps_pkg::FPS_TWO: state_d = same ? fps_pkg::FPS_ABLE : fps_pkg::FPS_ONE;
          fps_pkg::FPS_ABLE: state_d = same ? fps_pkg::FPS_ABLE : fps_pkg::FPS_ONE;
          default: state_d = fps_pkg::FPS_HUNT;
        endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state_q <= fps_pkg::FPS_HUNT;
      last_q <= 16'h0000;
    end
    else
    begin
      state_q <= state_d;
      if (cfg_valid)
        last_q <= cfg_word;
    end
  end

  assign matched = state_q == fps_pkg::FPS_ABLE;
endmodule // fps_match

// file: core/fps_regs.sv
// Purpose: fiber auto-negotiation partner ability and expansion registers behind APB
// Assumes: page and code group events are synchronous one-cycle strobes on pclk; link_up is a synchronous level
// Notes: registers answer with zero wait states; unmapped addresses read zero with pslverr
module fps_regs (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic soft_reset,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic link_up,
  input wire logic fx_mode,
  input wire logic page_valid,
  input wire logic page_is_base,
  input wire logic [15:0] page_word,
  input wire logic sync_ok,
  input wire logic cfg_valid,
  input wire logic [15:0] cfg_word,
  output logic irq
);
  logic [15:0] partner_q;
  logic peer_np_q;
  logic page_rx_q;
  logic [1:0] mode_q;
  logic an_en_q;
  logic [2:0] irq_stat_q;
  logic [2:0] irq_mask_q;
  logic link_q;
  logic peer_an_q;
  logic [31:0] prdata_q;
  logic pslverr_q;
  wire logic matched;

  // apb decode; zero wait states keeps the master's access phase to one cycle
  wire logic acc = psel && penable;
  wire logic wr = acc && pwrite;
  wire logic rd = acc && !pwrite;
  wire logic [9:0] a = paddr[9:0];
  wire logic hit_partner = a == fps_pkg::ADDR_PARTNER;
  wire logic hit_exp = a == fps_pkg::ADDR_EXPANSION;
  wire logic hit_stat = a == fps_pkg::ADDR_IRQ_STATUS;
  wire logic hit_mask = a == fps_pkg::ADDR_IRQ_MASK;
  wire logic hit_ctl = a == fps_pkg::ADDR_CONTROL;
  wire logic mapped = (paddr[31:10] == 22'h00_0000) && (paddr[1:0] == 2'b00) &&
    (hit_partner || hit_exp || hit_stat || hit_mask || hit_ctl);
  assign pready = 1'b1;

  // mode interpretation
  wire logic is_media = mode_q == fps_pkg::MODE_SGMII_MEDIA;
  wire logic is_1000bx = (mode_q == fps_pkg::MODE_1000BX) && !fx_mode;
  wire logic link_drop = link_q && !link_up;
  wire logic base_rx = page_valid && page_is_base;
  wire logic exp_read = rd && hit_exp;

  // expansion view: upper bits zero, local next page always able
  wire logic [15:0] exp_view = {12'h000, peer_np_q, 1'b1, page_rx_q, peer_an_q};

  fps_match u_match (
    .pclk(pclk),
    .presetn(presetn),
    .sync_ok(sync_ok),
    .cfg_valid(cfg_valid),
    .cfg_word(cfg_word),
    .matched(matched)
  );

  // partner-able needs sync, three matches and the enable together
  wire logic peer_an_d = sync_ok && matched && an_en_q;

  // event sources for the interrupt status
  wire logic [2:0] irq_evt = {peer_an_d && !peer_an_q, link_drop, page_valid};
  wire logic [2:0] irq_clr = (wr && hit_stat) ? pwdata[2:0] : 3'b000;

  // read mux
  logic [31:0] rd_mux;
  always_comb
  begin
    rd_mux = 32'h0000_0000;
    if (hit_partner)
      rd_mux = {16'h0000, partner_q};
    else if (hit_exp)
      rd_mux = {16'h0000, exp_view};
    else if (hit_stat)
      rd_mux = {29'h0000_0000, irq_stat_q};
    else if (hit_mask)
      rd_mux = {29'h0000_0000, irq_mask_q};
    else if (hit_ctl)
      rd_mux = {29'h0000_0000, an_en_q, mode_q};
  end

  // media-mode partner word; every field mirrors the received code word
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      partner_q <= fps_pkg::PARTNER_RST;
    else if (soft_reset)
      partner_q <= fps_pkg::PARTNER_RST;
    else if (is_media && link_drop)
      partner_q <= fps_pkg::PARTNER_RST;
    else if (is_media && base_rx)
      partner_q <= page_word;
  end

  // partner next-page flag; link loss beats a same-cycle page
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      peer_np_q <= 1'b0;
    else if (soft_reset || !is_1000bx)
      peer_np_q <= 1'b0;
    else if (link_drop)
      peer_np_q <= 1'b0;
    else if (base_rx && page_word[fps_pkg::CW_NEXT_PAGE])
      peer_np_q <= 1'b1;
  end

  // latched page flag: a page in the read cycle wins over the clear
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      page_rx_q <= 1'b0;
    else if (soft_reset)
      page_rx_q <= 1'b0;
    else if (page_valid)
      page_rx_q <= 1'b1;
    else if (exp_read)
      page_rx_q <= 1'b0;
  end

  // link history and partner-able flag
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      link_q <= 1'b0;
      peer_an_q <= 1'b0;
    end
    else
    begin
      link_q <= link_up;
      peer_an_q <= soft_reset ? 1'b0 : peer_an_d;
    end
  end

  // software control; mode and enable survive soft reset on purpose
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      mode_q <= fps_pkg::MODE_RST;
      an_en_q <= 1'b1;
      irq_mask_q <= 3'b000;
    end
    else
    begin
      if (wr && hit_ctl)
      begin
        mode_q <= pwdata[1:0];
        an_en_q <= pwdata[fps_pkg::CTL_AN_ENABLE];
      end
      if (wr && hit_mask)
        irq_mask_q <= pwdata[2:0];
    end
  end

  // sticky status, write one to clear; a new event wins over the clear
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      irq_stat_q <= 3'b000;
    else
      irq_stat_q <= (irq_stat_q & ~irq_clr) | irq_evt;
  end

  // registered read data and error
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata_q <= 32'h0000_0000;
      pslverr_q <= 1'b0;
    end
    else if (psel && !penable)
    begin
      prdata_q <= mapped ? rd_mux : 32'h0000_0000;
      pslverr_q <= !mapped;
    end
  end
  assign prdata = prdata_q;
  assign pslverr = pslverr_q && acc;
  assign irq = |(irq_stat_q & irq_mask_q);

  // checks
  chk_media_clear: assert property (@(posedge pclk) disable iff (!presetn)
    (is_media && link_drop && !soft_reset) |=> partner_q == 16'h0000)
    else $error("partner word not cleared on link loss");
  chk_media_load: assert property (@(posedge pclk) disable iff (!presetn)
    (is_media && base_rx && !link_drop && !soft_reset) |=> partner_q == $past(page_word))
    else $error("partner word not loaded from base page");
  chk_upper_zero: assert property (@(posedge pclk) disable iff (!presetn)
    exp_view[15:4] == 12'h000)
    else $error("expansion upper bits not zero");
  chk_np_held_low: assert property (@(posedge pclk) disable iff (!presetn)
    !is_1000bx |=> !peer_np_q)
    else $error("peer next page set outside 1000BASE-X");
  chk_np_set: assert property (@(posedge pclk) disable iff (!presetn)
    (is_1000bx && base_rx && page_word[15] && !link_drop && !soft_reset) |=> peer_np_q)
    else $error("peer next page not set");
  chk_np_clear: assert property (@(posedge pclk) disable iff (!presetn)
    link_drop |=> !peer_np_q)
    else $error("peer next page not cleared on link down");
  chk_local_np: assert property (@(posedge pclk) disable iff (!presetn)
    exp_view[2])
    else $error("local next page bit not one");
  chk_page_set: assert property (@(posedge pclk) disable iff (!presetn)
    (page_valid && !soft_reset) |=> page_rx_q)
    else $error("page flag not set");
  sequence s_read_flag;
    exp_read && page_rx_q && !page_valid && !soft_reset;
  endsequence
  chk_page_hold: assert property (@(posedge pclk) disable iff (!presetn)
    (page_rx_q && !exp_read && !soft_reset) |=> page_rx_q)
    else $error("page flag dropped without read");
  chk_page_clear: assert property (@(posedge pclk) disable iff (!presetn)
    s_read_flag |=> !page_rx_q)
    else $error("page flag not cleared by read");
  chk_an_able: assert property (@(posedge pclk) disable iff (!presetn)
    peer_an_q |-> $past(sync_ok && an_en_q))
    else $error("partner able set without sync and enable");
  chk_mode_pick: assert property (@(posedge pclk) disable iff (!presetn)
    (mode_q == fps_pkg::MODE_SGMII_SYS) |=> $stable(partner_q) || $past(soft_reset))
    else $error("partner word changed outside media mode");
endmodule // fps_regs

// file: testbench/fps_link_model.sv
// Purpose: link partner model sending base pages and config code groups
// Assumes: strobes last one pclk cycle and launch right after a rising edge
// Notes: idle word lines show the inverse of the last word, so a stale copy never passes
module fps_link_model (
  input wire logic pclk,
  output logic link_up,
  output logic page_valid,
  output logic page_is_base,
  output logic [15:0] page_word,
  output logic sync_ok,
  output logic cfg_valid,
  output logic [15:0] cfg_word
);
  timeunit 1ns;
  timeprecision 1ns;
  // link up and quiet at time zero
  initial
  begin
    link_up = 1'b1;
    page_valid = 1'b0;
    page_is_base = 1'b0;
    page_word = 16'h0000;
    sync_ok = 1'b0;
    cfg_valid = 1'b0;
    cfg_word = 16'h0000;
  end
  // a base page always carries bit 13 low and the fixed low pattern
  task automatic send_page(input logic [15:0] w);
    @(posedge pclk);
    page_valid <= 1'b1;
    page_is_base <= 1'b1;
    page_word <= {w[15:14], 1'b0, w[12:7], 7'h01};
    @(posedge pclk);
    page_valid <= 1'b0;
    page_is_base <= 1'b0;
    page_word <= ~page_word;
  endtask
  // one config code group
  task automatic send_cfg(input logic [15:0] w);
    @(posedge pclk);
    cfg_valid <= 1'b1;
    cfg_word <= w;
    @(posedge pclk);
    cfg_valid <= 1'b0;
    cfg_word <= ~cfg_word;
  endtask
  // link down for two cycles, then up again
  task automatic drop_link();
    @(posedge pclk);
    link_up <= 1'b0;
    repeat (2) @(posedge pclk);
    link_up <= 1'b1;
  endtask
  task automatic set_sync(input logic s);
    @(posedge pclk);
    sync_ok <= s;
  endtask
endmodule // fps_link_model

// file: testbench/fiber_autoneg_partner_status_tb_top.sv
// Purpose: self-checking bench for the partner ability and expansion registers
// Assumes: zero wait state APB slave; 100 ns clock
// Notes: every read waits for pready under the cycle ceiling
module fiber_autoneg_partner_status_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic pclk = 1'b0, presetn = 1'b0, soft_reset = 1'b0, fx_mode = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [31:0] paddr = 32'h0000_0000, pwdata = 32'h0000_0000, prdata, rdat;
  logic pready, pslverr, irq, rerr, link_up, page_valid, page_is_base, sync_ok, cfg_valid;
  logic [15:0] page_word, cfg_word, w;
  int n_mismatch = 0, n_tests = 0, cyc = 0;
  always #50 pclk = ~pclk;
  fps_link_model fps_link_model_inst (.pclk(pclk), .link_up(link_up), .page_valid(page_valid),
    .page_is_base(page_is_base), .page_word(page_word), .sync_ok(sync_ok), .cfg_valid(cfg_valid),
    .cfg_word(cfg_word));
  fps_regs fps_regs_inst (.pclk(pclk), .presetn(presetn), .soft_reset(soft_reset), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .link_up(link_up), .fx_mode(fx_mode), .page_valid(page_valid),
    .page_is_base(page_is_base), .page_word(page_word), .sync_ok(sync_ok), .cfg_valid(cfg_valid),
    .cfg_word(cfg_word), .irq(irq));
  task automatic end_sim();
    $display("mismatches %0d comparisons %0d", n_mismatch, n_tests);
    if (n_mismatch == 0 && n_tests > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  // a hang is cut short long after the sequence should be done
  always @(posedge pclk)
  begin
    cyc++;
    if (cyc > 5000)
    begin
      n_mismatch++;
      end_sim();
    end
  end
  // one APB transfer: setup, then access held until pready is seen
  task automatic apb(input logic wr, input logic [9:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= {22'h00_0000, a};
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("unexpected at %0t: word %h, wanted %h", $time, got, exp);
    end
  endtask
  task automatic chk_bit(input logic got, input logic exp);
    n_tests++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("unexpected at %0t: flag %b, wanted %b", $time, got, exp);
    end
  endtask
  task automatic rd(input logic [9:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0000_0000);
    chk_word(rdat, exp);
  endtask
  // main sequence
  initial
  begin
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    rd(fps_pkg::ADDR_PARTNER, 32'h0000_0000);
    rd(fps_pkg::ADDR_EXPANSION, 32'h0000_0004);
    // speed codes 0 to 2, with link, acknowledge and duplex bits varied
    for (int s = 0; s < 3; s++)
    begin
      w = {s[0], ~s[0], 1'b0, s[1], s[1:0], 3'b000, 7'h01};
      fps_link_model_inst.send_page(w);
      rd(fps_pkg::ADDR_PARTNER, {16'h0000, w});
      rd(fps_pkg::ADDR_EXPANSION, 32'h0000_0006);
      rd(fps_pkg::ADDR_EXPANSION, 32'h0000_0004);
    end
    fps_link_model_inst.drop_link();
    rd(fps_pkg::ADDR_PARTNER, 32'h0000_0000);
    // interrupt: page and link-down events, masked, unmasked, cleared
    rd(fps_pkg::ADDR_IRQ_STATUS, 32'h0000_0003);
    @(negedge pclk);
    chk_bit(irq, 1'b0);
    apb(1'b1, fps_pkg::ADDR_IRQ_MASK, 32'h0000_0002);
    @(negedge pclk);
    chk_bit(irq, 1'b1);
    apb(1'b1, fps_pkg::ADDR_IRQ_STATUS, 32'h0000_0002);
    @(negedge pclk);
    chk_bit(irq, 1'b0);
    rd(fps_pkg::ADDR_IRQ_STATUS, 32'h0000_0001);
    // 1000BASE-X: next-page flag set by a base page, cleared by link loss
    apb(1'b1, fps_pkg::ADDR_CONTROL, 32'h0000_0005);
    fps_link_model_inst.send_page(16'h8001);
    rd(fps_pkg::ADDR_EXPANSION, 32'h0000_000E);
    rd(fps_pkg::ADDR_PARTNER, 32'h0000_0000);
    fps_link_model_inst.drop_link();
    rd(fps_pkg::ADDR_EXPANSION, 32'h0000_0004);
    fx_mode <= 1'b1;
    fps_link_model_inst.send_page(16'h8001);
    rd(fps_pkg::ADDR_EXPANSION, 32'h0000_0006);
    fx_mode <= 1'b0;
    apb(1'b1, fps_pkg::ADDR_CONTROL, 32'h0000_0006);
    fps_link_model_inst.send_page(16'h8001);
    rd(fps_pkg::ADDR_EXPANSION, 32'h0000_0006);
    // partner able: sync, three matching groups, enable
    apb(1'b1, fps_pkg::ADDR_CONTROL, 32'h0000_0007);
    fps_link_model_inst.set_sync(1'b1);
    repeat (2) fps_link_model_inst.send_cfg(16'h4001);
    rd(fps_pkg::ADDR_EXPANSION, 32'h0000_0004);
    fps_link_model_inst.send_cfg(16'h4001);
    rd(fps_pkg::ADDR_EXPANSION, 32'h0000_0005);
    apb(1'b1, fps_pkg::ADDR_CONTROL, 32'h0000_0003);
    rd(fps_pkg::ADDR_EXPANSION, 32'h0000_0004);
    // every event source has fired since the last clear, the able edge included
    rd(fps_pkg::ADDR_IRQ_STATUS, 32'h0000_0007);
    // soft reset drops a freshly loaded partner word and the latched page flag
    fps_link_model_inst.send_page(16'hC401);
    rd(fps_pkg::ADDR_PARTNER, 32'h0000_C401);
    @(posedge pclk);
    soft_reset <= 1'b1;
    @(posedge pclk);
    soft_reset <= 1'b0;
    rd(fps_pkg::ADDR_PARTNER, 32'h0000_0000);
    rd(fps_pkg::ADDR_EXPANSION, 32'h0000_0004);
    // unmapped address is refused
    apb(1'b0, 10'h020, 32'h0000_0000);
    chk_bit(rerr, 1'b1);
    chk_word(rdat, 32'h0000_0000);
    end_sim();
  end
endmodule // fiber_autoneg_partner_status_tb_top
